// *** interval_timer_port.sv ***
// Programming and readout front end of a three-counter interval timer
// Operation
// - Control and latch words only at address 11
// - Addresses 00/01/10 load counters 0/1/2
// - Top bits pick counter; 11 is read-back, dropped by this front end
// - Access field: latch, LSB, MSB, LSB-then-MSB
// - Lowest bit picks binary or BCD counting
// - New count leaves programmed mode untouched
// - No defined counter state before programming; reset here loads MODE_0, LSB access and a zero count
// - Access field 00 means latch command
// - Latch freezes count until fully read
// - Latch leaves mode and counting alone
// - Each counter keeps its own latch
// - Repeat latch before read is ignored
// - Reads follow format; other accesses may interleave
// - Separate read and write byte sequencing
// - Single-byte format zeroes other count byte
// - Strobes need chip select; control read idles
`timescale 1ns/100ps
`default_nettype none
module interval_timer_port
  import timer_port_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_sel_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic port_select_hi_in,
  input wire logic port_select_lo_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  input wire logic [2:0] count_tick_in,
  input wire logic [2:0] count_gate_in,
  output logic [8:0] op_mode_out,
  output logic [2:0] bcd_mode_out,
  output logic [5:0] byte_access_out,
  output logic [47:0] count_value_out,
  output logic [2:0] latched_out
);

  logic wr_done;
  logic rd_active;
  logic rd_done;
  logic [1:0] addr;
  logic [7:0] wr_data;

  host_strobe_decode u_decode (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .chip_sel_n_in(chip_sel_n_in),
    .read_n_in(read_n_in),
    .write_n_in(write_n_in),
    .port_select_hi_in(port_select_hi_in),
    .port_select_lo_in(port_select_lo_in),
    .data_in(data_in),
    .wr_done_out(wr_done),
    .rd_active_out(rd_active),
    .rd_done_out(rd_done),
    .addr_out(addr),
    .wr_data_out(wr_data)
  );

  // Control word fields
  logic [1:0] cw_sel;
  logic [1:0] cw_acc;
  logic [2:0] cw_mode_bits;
  logic cw_bcd;
  logic setup_wr;

  assign cw_sel = wr_data[CW_SEL_HI:CW_SEL_LO];
  assign cw_acc = wr_data[CW_ACC_HI:CW_ACC_LO];
  assign cw_mode_bits = wr_data[CW_MODE_HI:CW_MODE_LO];
  assign cw_bcd = wr_data[CW_BCD];
  // Read-back selector is not served by this front end; such words are dropped
  assign setup_wr = wr_done && (addr == PORT_SETUP) && (cw_sel != SEL_READBACK);

  wire [7:0] rd_byte [0:NUM_COUNTERS-1];

  genvar i;
  generate
    for (i = 0; i < NUM_COUNTERS; i = i + 1) begin : g_cnt
      // Format group: written only by a setup word
      logic [1:0] acc_ff, nxt_acc;
      op_mode_t mode_ff, nxt_mode;
      logic bcd_ff, nxt_bcd;

      // Load group: count register, write sequencing and counting element
      logic [15:0] count_register_ff, nxt_count_register;
      logic [15:0] ce_ff, nxt_ce;
      byte_phase_t wr_ph_ff, nxt_wr_ph;
      logic load_pend_ff, nxt_load_pend;

      // Readout group: output latch and read sequencing
      logic [15:0] output_latch_ff, nxt_output_latch;
      logic latched_ff, nxt_latched;
      byte_phase_t rd_ph_ff, nxt_rd_ph;
      logic [15:0] ce_dec;
      logic [7:0] rd_sel_byte;
      logic hit, prog, latch_cmd, cnt_wr, cnt_rd;

      count_step u_step (
        .value_in(ce_ff),
        .bcd_in(bcd_ff),
        .value_out(ce_dec)
      );

      // Per-counter strobes from the shared decode
      assign hit = setup_wr && (cw_sel == 2'(i));
      assign prog = hit && (cw_acc != ACC_LATCH);
      assign latch_cmd = hit && (cw_acc == ACC_LATCH);
      assign cnt_wr = wr_done && (addr == 2'(i));
      assign cnt_rd = rd_done && (addr == 2'(i));

      always_comb begin
        nxt_acc = acc_ff;
        nxt_mode = mode_ff;
        nxt_bcd = bcd_ff;

        // Latch commands and count writes never reach this group
        if (prog) begin
          nxt_acc = cw_acc;
          nxt_mode = decode_mode(cw_mode_bits);
          nxt_bcd = cw_bcd;
        end
      end

      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          // Values are defined only so simulation starts clean; software must program first
          acc_ff <= RST_ACC;
          mode_ff <= MODE_0;
          bcd_ff <= 1'b0;
        end else begin
          acc_ff <= nxt_acc;
          mode_ff <= nxt_mode;
          bcd_ff <= nxt_bcd;
        end
      end

      always_comb begin
        nxt_count_register = count_register_ff;
        nxt_ce = ce_ff;
        nxt_wr_ph = wr_ph_ff;
        nxt_load_pend = load_pend_ff;

        // Transfer waits for a tick so both count bytes land together
        if (count_tick_in[i] && load_pend_ff) begin
          nxt_ce = count_register_ff;
          nxt_load_pend = 1'b0;
        end else if (count_tick_in[i] && count_gate_in[i]) begin
          nxt_ce = ce_dec;
        end

        if (prog) begin
          nxt_count_register = RST_COUNT;
          nxt_wr_ph = PH_LOW;
          nxt_load_pend = 1'b0;
        end else if (cnt_wr) begin
          // Mode and format are never touched by a count write
          unique case (acc_ff)
            ACC_MSB: begin
              nxt_count_register = {wr_data, ZERO_BYTE};
              nxt_load_pend = 1'b1;
            end
            ACC_WORD: begin
              if (wr_ph_ff == PH_LOW) begin
                nxt_count_register[7:0] = wr_data;
                nxt_wr_ph = PH_HIGH;
              end else begin
                nxt_count_register[15:8] = wr_data;
                nxt_wr_ph = PH_LOW;
                nxt_load_pend = 1'b1;
              end
            end
            default: begin
              nxt_count_register = {ZERO_BYTE, wr_data};
              nxt_load_pend = 1'b1;
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          count_register_ff <= RST_COUNT;
          ce_ff <= RST_COUNT;
          wr_ph_ff <= PH_LOW;
          load_pend_ff <= 1'b0;
        end else begin
          count_register_ff <= nxt_count_register;
          ce_ff <= nxt_ce;
          wr_ph_ff <= nxt_wr_ph;
          load_pend_ff <= nxt_load_pend;
        end
      end

      always_comb begin
        nxt_latched = latched_ff;
        nxt_rd_ph = rd_ph_ff;
        // Output latch follows the counting element unless frozen
        nxt_output_latch = latched_ff ? output_latch_ff : ce_ff;

        if (prog) begin
          nxt_latched = 1'b0;
          nxt_rd_ph = PH_LOW;
        end else if (latch_cmd) begin
          // A second latch before the read keeps the first capture
          if (!latched_ff) begin
            nxt_latched = 1'b1;
            nxt_output_latch = ce_ff;
          end
        end else if (cnt_rd) begin
          if (acc_ff == ACC_WORD && rd_ph_ff == PH_LOW) begin
            nxt_rd_ph = PH_HIGH;
          end else begin
            nxt_rd_ph = PH_LOW;
            nxt_latched = 1'b0;
          end
        end
      end

      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          output_latch_ff <= RST_COUNT;
          latched_ff <= 1'b0;
          rd_ph_ff <= PH_LOW;
        end else begin
          output_latch_ff <= nxt_output_latch;
          latched_ff <= nxt_latched;
          rd_ph_ff <= nxt_rd_ph;
        end
      end

      // Byte presented on a read follows the programmed format
      always_comb begin
        rd_sel_byte = output_latch_ff[7:0];
        unique case (acc_ff)
          ACC_MSB: begin
            rd_sel_byte = output_latch_ff[15:8];
          end
          ACC_WORD: begin
            if (rd_ph_ff == PH_HIGH) begin
              rd_sel_byte = output_latch_ff[15:8];
            end
          end
          default: begin
            rd_sel_byte = output_latch_ff[7:0];
          end
        endcase
      end

      assign rd_byte[i] = rd_sel_byte;

      // Observation outputs, each straight from a register above
      assign op_mode_out[3*i+2:3*i] = mode_ff;
      assign bcd_mode_out[i] = bcd_ff;
      assign byte_access_out[2*i+1:2*i] = acc_ff;
      assign count_value_out[16*i+15:16*i] = ce_ff;
      assign latched_out[i] = latched_ff;
    end
  endgenerate

  // Data bus drive: registered, one cycle behind the decoded strobe
  // Registering the drive keeps the enable free of decode glitches
  logic [7:0] dout_ff, nxt_dout;
  logic oe_n_ff, nxt_oe_n;

  always_comb begin
    nxt_dout = ZERO_BYTE;
    nxt_oe_n = 1'b1;
    // A read at the control address leaves the bus undriven
    if (rd_active && addr != PORT_SETUP) begin
      nxt_dout = rd_byte[addr];
      nxt_oe_n = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      dout_ff <= ZERO_BYTE;
      oe_n_ff <= 1'b1;
    end else begin
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign data_out = dout_ff;
  assign data_oe_n_out = oe_n_ff;

endmodule
`default_nettype wire

// *** timer_port_pkg.sv ***
// Shared constants and types for the interval timer programming and readout port
package timer_port_pkg;

  // Port addresses on the two select pins
  localparam logic [1:0] PORT_COUNT0 = 2'h0;
  localparam logic [1:0] PORT_COUNT1 = 2'h1;
  localparam logic [1:0] PORT_COUNT2 = 2'h2;
  localparam logic [1:0] PORT_SETUP = 2'h3;

  // Control word field positions
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_ACC_HI = 5;
  localparam int CW_ACC_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;

  // Target select codes
  localparam logic [1:0] SEL_READBACK = 2'h3;

  // Byte access codes
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB = 2'h1;
  localparam logic [1:0] ACC_MSB = 2'h2;
  localparam logic [1:0] ACC_WORD = 2'h3;

  localparam int NUM_COUNTERS = 3;
  localparam int DIGITS = 4;

  // Reset values of the per-counter and strobe decode state, and the zero fill byte
  localparam logic [1:0] RST_ACC = ACC_LSB;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MODE_0 = 3'b000,
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101
  } op_mode_t;

  typedef enum logic {
    PH_LOW = 1'b0,
    PH_HIGH = 1'b1
  } byte_phase_t;

  // Top mode bit is ignored once op_mode_bit1 is set
  function automatic op_mode_t decode_mode(input logic [2:0] bits);
    op_mode_t m;
    m = MODE_0;
    if (bits[1]) begin
      m = op_mode_t'({1'b0, bits[1:0]});
    end else begin
      m = op_mode_t'(bits);
    end
    return m;
  endfunction

endpackage

// *** host_strobe_decode.sv ***
// Chip-select qualification and strobe edge decode for the host port
`timescale 1ns/100ps
`default_nettype none
module host_strobe_decode
  import timer_port_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_sel_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic port_select_hi_in,
  input wire logic port_select_lo_in,
  input wire logic [7:0] data_in,
  output logic wr_done_out,
  output logic rd_active_out,
  output logic rd_done_out,
  output logic [1:0] addr_out,
  output logic [7:0] wr_data_out
);

  logic wr_act_ff, nxt_wr_act;
  logic rd_act_ff, nxt_rd_act;
  logic wr_done_ff, nxt_wr_done;
  logic rd_done_ff, nxt_rd_done;
  logic [1:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;

  // Strobes count only with chip select low; data is taken at the strobe's end
  always_comb begin
    nxt_wr_act = !chip_sel_n_in && !write_n_in;
    nxt_rd_act = !chip_sel_n_in && !read_n_in;
    nxt_wr_done = wr_act_ff && !nxt_wr_act;
    nxt_rd_done = rd_act_ff && !nxt_rd_act;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    if (nxt_wr_act || nxt_rd_act) begin
      nxt_addr = {port_select_hi_in, port_select_lo_in};
    end
    if (nxt_wr_act) begin
      nxt_wdata = data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      wr_done_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      addr_ff <= PORT_COUNT0;
      wdata_ff <= RST_BYTE;
    end else begin
      wr_act_ff <= nxt_wr_act;
      rd_act_ff <= nxt_rd_act;
      wr_done_ff <= nxt_wr_done;
      rd_done_ff <= nxt_rd_done;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  assign wr_done_out = wr_done_ff;
  assign rd_active_out = rd_act_ff;
  assign rd_done_out = rd_done_ff;
  assign addr_out = addr_ff;
  assign wr_data_out = wdata_ff;

endmodule
`default_nettype wire

// *** count_step.sv ***
// One down-count step of a counting element, plain binary or four decimal decades
`timescale 1ns/100ps
`default_nettype none
module count_step
  import timer_port_pkg::*;
(
  input wire logic [15:0] value_in,
  input wire logic bcd_in,
  output logic [15:0] value_out
);

  wire [DIGITS:0] borrow;
  wire [15:0] bcd_next;

  assign borrow[0] = 1'b1;

  // Each decade wraps 0 to 9 and borrows from the next one up
  genvar d;
  generate
    for (d = 0; d < DIGITS; d = d + 1) begin : g_digit
      wire [3:0] digit;
      assign digit = value_in[4*d+3:4*d];
      assign borrow[d+1] = borrow[d] && (digit == 4'h0);
      assign bcd_next[4*d+3:4*d] = !borrow[d] ? digit :
                                   (digit == 4'h0) ? 4'h9 : digit - 4'h1;
    end
  endgenerate

  assign value_out = bcd_in ? bcd_next : value_in - 16'h0001;

endmodule
`default_nettype wire

// *** timer_port_monitor.sv ***
// Checker for the interval timer port's bus and counter state outputs
`timescale 1ns/100ps
`default_nettype none
module timer_port_monitor
  import timer_port_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_sel_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic port_select_hi_in,
  input wire logic port_select_lo_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_n_out,
  input wire logic [2:0] count_tick_in,
  input wire logic [8:0] op_mode_out,
  input wire logic [2:0] bcd_mode_out,
  input wire logic [5:0] byte_access_out,
  input wire logic [47:0] count_value_out,
  input wire logic [2:0] latched_out
);
  logic wr_act;
  logic rd_act;
  logic setup;
  logic cw_end;
  logic wr_ff;
  logic [1:0] adr_ff;
  logic [7:0] dat_ff;
  logic [2:0] mode_exp;
  assign wr_act = !chip_sel_n_in && !write_n_in;
  assign rd_act = !chip_sel_n_in && !read_n_in;
  assign setup = port_select_hi_in && port_select_lo_in;
  // A write counts once its strobe drops, with the last address and data it held
  assign cw_end = wr_ff && !wr_act && adr_ff == PORT_SETUP;
  assign mode_exp = dat_ff[2] ? {1'b0, dat_ff[2:1]} : dat_ff[3:1];
  always_ff @(posedge ref_clk_in) begin
    wr_ff <= wr_act;
    if (wr_act) begin
      adr_ff <= {port_select_hi_in, port_select_lo_in};
      dat_ff <= data_in;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_ctrl_read_idle: assert property ((rd_act && setup) [*4] |-> data_oe_n_out)
    else $error("control address read drove the bus");
  a_cs_blocks_bus: assert property (chip_sel_n_in [*4] |-> data_oe_n_out)
    else $error("bus driven without chip select");
  a_read_drives_bus: assert property ((rd_act && !setup) [*4] |-> !data_oe_n_out)
    else $error("counter read left the bus undriven");
  a_setup_loads_mode: assert property (cw_end && dat_ff[7:6] == 2'h0 && dat_ff[5:4] != ACC_LATCH
    |-> ##3 op_mode_out[2:0] == $past(mode_exp, 3) && byte_access_out[1:0] == $past(dat_ff[5:4], 3)
    && bcd_mode_out[0] == $past(dat_ff[0], 3)) else $error("setup word not applied");
  a_latch_keeps_mode: assert property (cw_end && dat_ff[5:4] == ACC_LATCH
    |-> ##3 op_mode_out == $past(op_mode_out, 3)) else $error("latch changed a mode");
  a_latch_sets_flag: assert property (cw_end && dat_ff[7:4] == 4'h0 |-> ##3 latched_out[0])
    else $error("latch command not taken");
  a_setup_drops_latch: assert property (cw_end && dat_ff[7:6] == 2'h0 && dat_ff[5:4] != 2'h0
    |-> ##3 !latched_out[0]) else $error("setup word left a latch held");
  a_readback_ignored: assert property (cw_end && dat_ff[7:6] == SEL_READBACK
    |-> ##3 byte_access_out == $past(byte_access_out, 3)) else $error("select 11 word applied");
  a_count_holds: assert property (!count_tick_in[0] |=> $stable(count_value_out[15:0]))
    else $error("count moved without a tick");
  c_latch: cover property (cw_end && dat_ff[7:4] == 4'h0);
  c_read: cover property ((rd_act && !setup) [*4]);
  c_readback: cover property (cw_end && dat_ff[7:6] == SEL_READBACK);
endmodule
`default_nettype wire

// *** host_cpu_model.sv ***
// Host processor model: write and read cycles on the timer's 8-bit port
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic oe_n_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic sel_hi_out,
  output logic sel_lo_out,
  output logic [7:0] wr_data_out
);
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    {sel_hi_out, sel_lo_out} = 2'h0;
    wr_data_out = 8'h00;
  end
  // Single host: no other routine splits a two-byte write or read
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic cs = 1'b0);
    @(negedge clk_in);
    cs_n_out = cs;
    {sel_hi_out, sel_lo_out} = a;
    wr_data_out = d;
    wr_n_out = 1'b0;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    // Released data lines must not keep showing the written byte
    wr_data_out = ~d;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] q, output logic oe);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    {sel_hi_out, sel_lo_out} = a;
    rd_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    q = rd_data_in;
    oe = oe_n_in;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** interval_timer_port_bench.sv ***
// Testbench for the interval timer programming and readout port
`timescale 1ns/100ps
`default_nettype none
module interval_timer_port_bench;
  import timer_port_pkg::*;
  logic ref_clk_in, sys_rst_in, chip_sel_n_in, read_n_in, write_n_in;
  logic port_select_hi_in, port_select_lo_in, data_oe_n_out, oe;
  logic [7:0] data_in, data_out, q;
  logic [2:0] count_tick_in, count_gate_in, bcd_mode_out, latched_out;
  logic [8:0] op_mode_out;
  logic [5:0] byte_access_out;
  logic [47:0] count_value_out;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  interval_timer_port dut (.ref_clk_in, .sys_rst_in, .chip_sel_n_in, .read_n_in,
    .write_n_in, .port_select_hi_in, .port_select_lo_in, .data_in, .data_out,
    .data_oe_n_out, .count_tick_in, .count_gate_in, .op_mode_out, .bcd_mode_out,
    .byte_access_out, .count_value_out, .latched_out);
  host_cpu_model h (.clk_in(ref_clk_in), .rd_data_in(data_out), .oe_n_in(data_oe_n_out),
    .cs_n_out(chip_sel_n_in), .rd_n_out(read_n_in), .wr_n_out(write_n_in),
    .sel_hi_out(port_select_hi_in), .sel_lo_out(port_select_lo_in), .wr_data_out(data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    h.rd(a, q, oe);
    chk(q, e);
    chk(oe, 1'b0);
  endtask
  task automatic tick(input int n, input int c);
    repeat (n) begin
      @(negedge ref_clk_in);
      count_tick_in[c] = 1'b1;
      @(negedge ref_clk_in);
      count_tick_in[c] = 1'b0;
    end
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    sys_rst_in = 1'b1;
    count_tick_in = 3'h0;
    count_gate_in = 3'h7;
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk(data_oe_n_out, 1'b1);
    h.wr(2'h3, 8'h34);
    chk(op_mode_out[2:0], 3'h2);
    chk(byte_access_out[1:0], 2'h3);
    for (int m = 0; m < 8; m++) begin
      h.wr(2'h3, {4'h5, m[2:0], m[0]});
      chk(op_mode_out[5:3], m[1] ? {1'b0, m[1:0]} : m[2:0]);
      chk(bcd_mode_out[1], m[0]);
    end
    h.wr(2'h1, 8'h00);
    tick(2, 1);
    chk(count_value_out[31:16], 16'h9999);
    h.wr(2'h0, 8'h34);
    h.wr(2'h0, 8'h12);
    tick(3, 0);
    chk(count_value_out[15:0], 16'h1232);
    h.wr(2'h3, 8'h00);
    tick(1, 0);
    h.wr(2'h3, 8'h00);
    chk(op_mode_out[2:0], 3'h2);
    rdc(2'h0, 8'h32);
    rdc(2'h0, 8'h12);
    chk(latched_out[0], 1'b0);
    count_gate_in = 3'h0;
    rdc(2'h0, 8'h31);
    h.wr(2'h0, 8'h78);
    rdc(2'h0, 8'h12);
    h.wr(2'h0, 8'h9A);
    tick(1, 0);
    chk(count_value_out[15:0], 16'h9A78);
    chk(op_mode_out[2:0], 3'h2);
    h.wr(2'h3, 8'hA0);
    h.wr(2'h2, 8'h56);
    tick(1, 2);
    chk(count_value_out[47:32], 16'h5600);
    h.wr(2'h3, 8'h00);
    h.wr(2'h3, 8'h80);
    chk(latched_out, 3'h5);
    rdc(2'h0, 8'h78);
    rdc(2'h2, 8'h56);
    chk(latched_out, 3'h1);
    rdc(2'h0, 8'h9A);
    h.wr(2'h3, 8'h12, 1'b1);
    h.wr(2'h3, 8'hC2);
    chk(byte_access_out, 6'h27);
    h.rd(2'h3, q, oe);
    chk(oe, 1'b1);
    h.wr(2'h0, 8'hEE);
    h.wr(2'h3, 8'h00);
    h.wr(2'h3, 8'h30);
    chk(latched_out[0], 1'b0);
    h.wr(2'h0, 8'h11);
    h.wr(2'h0, 8'h22);
    tick(1, 0);
    chk(count_value_out[15:0], 16'h2211);
    chk(op_mode_out[2:0], 3'h0);
    finish_test();
  end
endmodule
bind interval_timer_port timer_port_monitor mon (.ref_clk_in, .sys_rst_in, .chip_sel_n_in,
  .read_n_in, .write_n_in, .port_select_hi_in, .port_select_lo_in, .data_in,
  .data_oe_n_out, .count_tick_in, .op_mode_out, .bcd_mode_out, .byte_access_out,
  .count_value_out, .latched_out);
`default_nettype wire
